// ### include/setup_regs_pkg.sv
// package: register map, field layout and shared types for the setup capture block
package setup_regs_pkg;

    // ------------------------------------------------------------
    // register byte addresses (aligned words)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SETUP_VALUE  = 8'h00; // setup_value_capture
    localparam logic [7:0] OFS_SETUP_INDEX  = 8'h04; // setup_index_capture
    localparam logic [7:0] OFS_SETUP_LENGTH = 8'h08; // setup_length_capture
    localparam logic [7:0] OFS_EVENT_FLAGS  = 8'h0C; // event_flags_and_masks
    localparam logic [7:0] OFS_FRAME_CTRL   = 8'h10; // self frame mode control

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          MASK_LSB        = 8;      // masks sit in 15..8
    localparam int          FLAG_LSB        = 0;      // flags sit in 7..0
    localparam int          EV_NAK          = 7;      // event index: nak
    localparam int          EV_EP           = 6;      // endpoint done
    localparam int          EV_EP0          = 5;      // ctrl endpoint done
    localparam int          EV_SOF          = 4;      // frame start
    localparam int          EV_RX0          = 3;      // zero-length receive
    localparam int          EV_STATUS       = 2;      // status stage done
    localparam int          EV_STATUS_NAK   = 1;      // status nak
    localparam int          EV_SETUP        = 0;      // setup received
    localparam logic [7:0]  MASK_RESET      = 8'h00;  // all masks open
    localparam logic [7:0]  FLAG_RESET      = 8'h00;  // no events pending
    localparam logic [15:0] CAPTURE_RESET   = 16'h0000;
    localparam int          SETUP_BYTES     = 8;      // bytes per setup packet
    localparam logic [2:0]  LAST_BYTE_IDX   = 3'h7;   // index of eighth byte

    // ------------------------------------------------------------
    // timing: one full speed frame
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 125;          // sys_clk rate
    localparam int FRAME_TIME_US  = 1000;         // one frame, in us
    localparam int FRAME_CYCLES   = FRAME_TIME_US * CLK_MHZ;

    // ------------------------------------------------------------
    // axi4-lite responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // incoming setup byte stream from the packet engine
    typedef struct packed {
        logic       valid;   // byte strobe
        logic       first;   // first byte of a setup packet
        logic [7:0] data;    // byte value
    } setup_byte_t;

    // controller events, one cycle pulses, in flag bit order
    typedef logic [7:0] event_vec_t;

endpackage

// ### verilog/setup_byte_capture.sv
// module: assembles setup packet bytes three to eight into the three field words
`timescale 1ns/1ps
module setup_byte_capture (
    input  wire logic                        sys_clk,   // system clock
    input  wire logic                        reset_n,   // async reset, low
    input  wire setup_regs_pkg::setup_byte_t setup_in,  // byte stream
    output logic [15:0]                      value_reg,  // captured wValue
    output logic [15:0]                      index_reg,  // captured wIndex
    output logic [15:0]                      length_reg, // captured wLength
    output logic                             done_pulse  // eighth byte taken
);

    // ------------------------------------------------------------
    // byte position tracking
    // ------------------------------------------------------------
    logic [2:0] pos_reg;   // index of the next byte
    logic [2:0] pos_now;   // index of the byte in this cycle
    logic       take;      // a byte is present

    assign take    = setup_in.valid;
    assign pos_now = setup_in.first ? 3'h0 : pos_reg;

    // position counter, restarts on every first byte
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_reg <= 3'h0;
        end else if (take) begin
            pos_reg <= pos_now + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // field latches: hold until the next packet overwrites them
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            value_reg  <= setup_regs_pkg::CAPTURE_RESET;
            index_reg  <= setup_regs_pkg::CAPTURE_RESET;
            length_reg <= setup_regs_pkg::CAPTURE_RESET;
        end else if (take) begin
            case (pos_now)
                3'h2: value_reg[7:0]   <= setup_in.data;
                3'h3: value_reg[15:8]  <= setup_in.data;
                3'h4: index_reg[7:0]   <= setup_in.data;
                3'h5: index_reg[15:8]  <= setup_in.data;
                3'h6: length_reg[7:0]  <= setup_in.data;
                3'h7: length_reg[15:8] <= setup_in.data;
                default: ;                                // request bytes not kept here
            endcase
        end
    end

    assign done_pulse = take && (pos_now == setup_regs_pkg::LAST_BYTE_IDX);

endmodule

// ### verilog/frame_timer.sv
// module: frame start timer for self generated frame mode
`timescale 1ns/1ps
module frame_timer #(
    parameter int FRAME_CYCLES = setup_regs_pkg::FRAME_CYCLES // cycles per frame
) (
    input  wire logic sys_clk,   // system clock
    input  wire logic reset_n,   // async reset, low
    input  wire logic enable,    // self frame mode on
    output logic      tick       // one cycle pulse per frame
);

    // ------------------------------------------------------------
    // frame counter
    // ------------------------------------------------------------
    logic [31:0] count_reg;      // cycles elapsed in this frame
    logic        wrap;           // last cycle of the frame

    assign wrap = (count_reg == 32'(FRAME_CYCLES - 1));
    assign tick = enable && wrap;

    // counter restarts when the mode is switched off
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= 32'h0000_0000;
        end else if (!enable || wrap) begin
            count_reg <= 32'h0000_0000;
        end else begin
            count_reg <= count_reg + 32'h0000_0001;
        end
    end

endmodule

// ### verilog/usb_setup_capture_regs.sv
// module: setup packet capture and event flag/mask register file on axi4-lite
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module usb_setup_capture_regs #(
    parameter int FRAME_CYCLES = setup_regs_pkg::FRAME_CYCLES // shorten for simulation
) (
    input  wire logic                        sys_clk,        // 125 MHz clock
    input  wire logic                        reset_n,        // async reset, low
    // axi4-lite slave
    input  wire logic [7:0]                  s_axi_awaddr,   // write address
    input  wire logic                        s_axi_awvalid,  // write address valid
    output logic                             s_axi_awready,  // write address ready
    input  wire logic [31:0]                 s_axi_wdata,    // write data
    input  wire logic [3:0]                  s_axi_wstrb,    // write byte enables
    input  wire logic                        s_axi_wvalid,   // write data valid
    output logic                             s_axi_wready,   // write data ready
    output logic [1:0]                       s_axi_bresp,    // write response
    output logic                             s_axi_bvalid,   // write response valid
    input  wire logic                        s_axi_bready,   // write response ready
    input  wire logic [7:0]                  s_axi_araddr,   // read address
    input  wire logic                        s_axi_arvalid,  // read address valid
    output logic                             s_axi_arready,  // read address ready
    output logic [31:0]                      s_axi_rdata,    // read data
    output logic [1:0]                       s_axi_rresp,    // read response
    output logic                             s_axi_rvalid,   // read data valid
    input  wire logic                        s_axi_rready,   // read data ready
    // controller side
    input  wire setup_regs_pkg::setup_byte_t setup_in,       // setup byte stream
    input  wire setup_regs_pkg::event_vec_t  event_in,       // event pulses
    output logic [7:0]                       int_out         // masked event outputs
);

    // ------------------------------------------------------------
    // setup capture and frame timer
    // ------------------------------------------------------------
    logic [15:0] value_reg;      // captured wValue
    logic [15:0] index_reg;      // captured wIndex
    logic [15:0] length_reg;     // captured wLength
    logic        setup_done;     // eighth byte seen
    logic        self_frame_reg; // self generated frame mode
    logic        frame_tick;     // timer frame pulse

    // fields live in the capture module and hold until overwritten
    setup_byte_capture u_capture (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .setup_in   (setup_in),
        .value_reg  (value_reg),
        .index_reg  (index_reg),
        .length_reg (length_reg),
        .done_pulse (setup_done)
    );

    frame_timer #(
        .FRAME_CYCLES (FRAME_CYCLES)
    ) u_frame (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .enable  (self_frame_reg),
        .tick    (frame_tick)
    );

    // ------------------------------------------------------------
    // write channel: take address and data in either order
    // ------------------------------------------------------------
    logic        aw_held_reg;    // write address captured
    logic [7:0]  aw_addr_reg;    // captured write address
    logic        w_held_reg;     // write data captured
    logic [31:0] w_data_reg;     // captured write data
    logic [3:0]  w_strb_reg;     // captured byte enables
    logic        bvalid_reg;     // write response pending
    logic [1:0]  bresp_reg;      // write response code
    logic        wr_fire;        // both halves present, do the write
    logic        wr_hit_flags;   // write targets the flag register
    logic        wr_hit_ctrl;    // write targets frame control
    logic        wr_ok;          // address is mapped

    // ready only while the half is empty and no response waits
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_hit_flags  = wr_fire && (aw_addr_reg == setup_regs_pkg::OFS_EVENT_FLAGS);
    assign wr_hit_ctrl   = wr_fire && (aw_addr_reg == setup_regs_pkg::OFS_FRAME_CTRL);
    assign wr_ok         = is_mapped(aw_addr_reg);
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    // decoder shared by both channels
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == setup_regs_pkg::OFS_SETUP_VALUE)
                 || (addr == setup_regs_pkg::OFS_SETUP_INDEX)
                 || (addr == setup_regs_pkg::OFS_SETUP_LENGTH)
                 || (addr == setup_regs_pkg::OFS_EVENT_FLAGS)
                 || (addr == setup_regs_pkg::OFS_FRAME_CTRL);
    endfunction

    // address half
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    // data half
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // response; read-only words accept the write silently
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= setup_regs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_ok ? setup_regs_pkg::RESP_OKAY : setup_regs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // mask and flag register
    // ------------------------------------------------------------
    logic [7:0] mask_reg;        // output masks, 1 blocks
    logic [7:0] flag_reg;        // sticky event flags
    logic [7:0] flag_next;       // flags after set and clear
    logic [7:0] set_vec;         // hardware set terms
    logic [7:0] clr_vec;         // software write-one clears
    logic       mask_we;         // mask byte written

    assign mask_we = wr_hit_flags && w_strb_reg[1];
    assign clr_vec = (wr_hit_flags && w_strb_reg[0]) ? w_data_reg[7:0] : 8'h00;

    // event sources; frame start also comes from the timer
    generate
        for (genvar i = 0; i < 8; i++) begin : g_set
            if (i == setup_regs_pkg::EV_SOF) begin : g_sof
                assign set_vec[i] = event_in[i] || frame_tick;
            end else if (i == setup_regs_pkg::EV_SETUP) begin : g_setup
                assign set_vec[i] = event_in[i] || setup_done;
            end else begin : g_plain
                assign set_vec[i] = event_in[i];
            end
        end
    endgenerate

    // set wins over a clear in the same cycle
    assign flag_next = (flag_reg & ~clr_vec) | set_vec;

    // flags: hardware sets, software clears
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg <= setup_regs_pkg::FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // masks: written only through byte lane one
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_reg <= setup_regs_pkg::MASK_RESET;
        end else if (mask_we) begin
            mask_reg <= w_data_reg[15:8];
        end
    end

    // frame control: bit 0 selects self generated frames
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            self_frame_reg <= 1'b0;
        end else if (wr_hit_ctrl && w_strb_reg[0]) begin
            self_frame_reg <= w_data_reg[0];
        end
    end

    // outputs follow flags combinationally gated by masks
    assign int_out = flag_reg & ~mask_reg;

    // ------------------------------------------------------------
    // read channel: one cycle answer, held until rready
    // ------------------------------------------------------------
    logic        rvalid_reg;     // read answer pending
    logic [31:0] rdata_reg;      // read answer data
    logic [1:0]  rresp_reg;      // read answer code
    logic [31:0] rd_word;        // selected word
    logic        rd_take;        // read address accepted
    logic [7:0]  rd_addr;        // word aligned read address

    assign s_axi_arready = !rvalid_reg;
    assign rd_take       = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign rd_addr       = {s_axi_araddr[7:2], 2'b00};

    // upper half reads as zero
    assign rd_word =
        (rd_addr == setup_regs_pkg::OFS_SETUP_VALUE)  ? {16'h0000, value_reg}  :
        (rd_addr == setup_regs_pkg::OFS_SETUP_INDEX)  ? {16'h0000, index_reg}  :
        (rd_addr == setup_regs_pkg::OFS_SETUP_LENGTH) ? {16'h0000, length_reg} :
        (rd_addr == setup_regs_pkg::OFS_EVENT_FLAGS)  ? {16'h0000, mask_reg, flag_reg} :
        (rd_addr == setup_regs_pkg::OFS_FRAME_CTRL)   ? {31'h0, self_frame_reg} :
        32'h0000_0000;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= setup_regs_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= is_mapped(rd_addr) ? setup_regs_pkg::RESP_OKAY
                                             : setup_regs_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // flag set and clear
    flag_sticky_a: assert property (
        set_vec[setup_regs_pkg::EV_EP0]
        |=> flag_reg[setup_regs_pkg::EV_EP0])
        else $error("ep0 flag not set after event");

    sof_set_a: assert property (
        frame_tick
        |=> flag_reg[setup_regs_pkg::EV_SOF])
        else $error("frame flag not set after timer tick");

    set_beats_clear_a: assert property (
        (set_vec[3] && clr_vec[3])
        |=> flag_reg[3])
        else $error("clear beat a set");

    clear_works_a: assert property (
        (clr_vec[6] && !set_vec[6])
        |=> !flag_reg[6])
        else $error("write one did not clear flag");

    setup_flag_a: assert property (
        setup_done
        |=> flag_reg[setup_regs_pkg::EV_SETUP])
        else $error("setup flag not set after eighth byte");

    // masks: storage and gating
    mask_gate_a: assert property (
        mask_reg[2]
        |-> !int_out[2])
        else $error("masked flag reached output");

    mask_pass_a: assert property (
        (!mask_reg[5] && flag_reg[5])
        |-> int_out[5])
        else $error("unmasked flag blocked");

    mask_write_a: assert property (
        mask_we
        |=> mask_reg == $past(w_data_reg[15:8]))
        else $error("mask byte not stored");

    // setup field capture
    value_low_a: assert property (
        (setup_in.valid && !setup_in.first && u_capture.pos_reg == 3'h2)
        |=> value_reg[7:0] == $past(setup_in.data))
        else $error("third byte not captured");

    length_high_a: assert property (
        setup_done
        |=> length_reg[15:8] == $past(setup_in.data))
        else $error("eighth byte not captured");

    fields_hold_a: assert property (
        !setup_in.valid
        |=> $stable(index_reg))
        else $error("index changed without a byte");

    // bus answers
    write_answer_a: assert property (
        wr_fire
        |=> bvalid_reg)
        else $error("write answer late");

    read_answer_a: assert property (
        rd_take
        |=> rvalid_reg && rdata_reg[31:16] == 16'h0000)
        else $error("read answer late or upper bits set");

    // main scenarios
    setup_seen_c: cover property (setup_done);
    frame_tick_c: cover property (frame_tick ##1 flag_reg[setup_regs_pkg::EV_SOF]);
    irq_out_c:    cover property (|int_out);
    clear_c:      cover property (|clr_vec);
    set_clear_c:  cover property (set_vec[3] && clr_vec[3]);

endmodule

// ### testbench/setup_host.sv
// partner model: usb host side feeding setup packet bytes
`timescale 1ns/1ps
module setup_host (
    input  wire logic                  sys_clk,   // system clock
    output setup_regs_pkg::setup_byte_t setup_out  // byte stream to device
);
    // idle stream between packets shows the inverted last byte, so a stale copy is never mistaken for data
    initial setup_out = '0;
    // one whole packet, byte one first, no gaps
    task automatic send(input logic [63:0] pkt);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            setup_out <= {1'b1, i == 0, pkt[8*i +: 8]}; // low byte of each field first
        end
        @(posedge sys_clk);
        setup_out <= {2'b00, ~pkt[63:56]};
    endtask
endmodule

// ### testbench/testbench.sv
// testbench: setup capture and event register block over axi4-lite
`timescale 1ns/1ps
module testbench;
    logic        sys_clk = 1'b0, reset_n = 1'b0;          // clock and reset
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // addresses
    logic [31:0] s_axi_wdata = 32'h0;                     // write data
    logic [3:0]  s_axi_wstrb = 4'h0;                      // byte enables
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;                // responses
    logic [31:0] s_axi_rdata;                             // read data
    logic [7:0]  event_in = 8'h00, int_out, mk;           // events, outputs, mask
    setup_regs_pkg::setup_byte_t setup_in;                // from host model
    integer      failures = 0, checks_done = 0, seed = 68606;
    logic [31:0] rd;                                      // last read word
    logic [1:0]  rs;                                      // last response
    logic [63:0] pkt;                                     // current packet
    localparam int FC = 20;                               // shortened frame
    always #4 sys_clk = ~sys_clk;
    usb_setup_capture_regs #(.FRAME_CYCLES(FC)) i_usb_setup_capture_regs (.sys_clk(sys_clk), .reset_n(reset_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .setup_in(setup_in),
        .event_in(event_in), .int_out(int_out));
    setup_host i_setup_host (.sys_clk(sys_clk), .setup_out(setup_in));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // handshakes judged just before the rising edge, acted on right after it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_hs, w_hs, b_hs;
        int n;
        n = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(negedge sys_clk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge sys_clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            n++;
        end while (b_hs !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        check("bvalid", b_hs, 1'b1);
        @(posedge sys_clk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ar_hs, r_hs;
        int n;
        n = 0;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin
            @(negedge sys_clk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge sys_clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            n++;
        end while (r_hs !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        check("rvalid", r_hs, 1'b1);
        @(posedge sys_clk);
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_rd(a);
        check(n, rd, e);
        check("rresp", rs, er);
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        axi_wr(a, d, s);
        check("bresp", rs, er);
    endtask
    // expected field word: upper half reads as zero
    function automatic logic [31:0] fld(input logic [63:0] p, input int b);
        return {16'h0000, p[8*b+8 +: 8], p[8*b +: 8]};
    endfunction
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog: whole run is a few hundred cycles
    initial begin
        #200000;
        failures++;
        final_report();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        for (int a = 0; a < 8'h14; a += 4) rd_chk("reset word", a, 32'h0, setup_regs_pkg::RESP_OKAY);
        rd_chk("unmapped", 8'h14, 32'h0, setup_regs_pkg::RESP_SLVERR);
        for (int k = 0; k < 3; k++) begin
            pkt = {$random(seed), $random(seed)};
            if (k == 0) i_setup_host.send(~pkt); // one idle cycle apart, first one overwritten
            i_setup_host.send(pkt);
            @(posedge sys_clk);
            rd_chk("value", setup_regs_pkg::OFS_SETUP_VALUE, fld(pkt, 2), 2'h0);
            rd_chk("index", setup_regs_pkg::OFS_SETUP_INDEX, fld(pkt, 4), 2'h0);
            rd_chk("length", setup_regs_pkg::OFS_SETUP_LENGTH, fld(pkt, 6), 2'h0);
            rd_chk("setup flag", setup_regs_pkg::OFS_EVENT_FLAGS, 32'h1, 2'h0);
            wr_chk(setup_regs_pkg::OFS_SETUP_VALUE, $random(seed), 4'hF, 2'h0);
            rd_chk("value kept", setup_regs_pkg::OFS_SETUP_VALUE, fld(pkt, 2), 2'h0);
            wr_chk(setup_regs_pkg::OFS_EVENT_FLAGS, 32'hFF, 4'h1, 2'h0);
        end
        for (int i = 0; i < 8; i++) begin
            event_in <= 8'h01 << i;
            @(posedge sys_clk);
            event_in <= 8'h00;
            @(negedge sys_clk);
            check("int_out open", int_out, 8'h01 << i);
            @(posedge sys_clk);
            rd_chk("flag", setup_regs_pkg::OFS_EVENT_FLAGS, 32'h1 << i, 2'h0);
            mk = $random(seed);
            wr_chk(setup_regs_pkg::OFS_EVENT_FLAGS, {16'h0, mk, 8'h00}, 4'h2, 2'h0);
            @(negedge sys_clk);
            check("int_out masked", int_out, (8'h01 << i) & ~mk);
            @(posedge sys_clk);
            rd_chk("mask", setup_regs_pkg::OFS_EVENT_FLAGS, {16'h0, mk, 8'h01 << i}, 2'h0);
            wr_chk(setup_regs_pkg::OFS_EVENT_FLAGS, 32'hFF, 4'h3, 2'h0);
            rd_chk("cleared", setup_regs_pkg::OFS_EVENT_FLAGS, 32'h0, 2'h0);
        end
        event_in <= 8'h08; // rx0 event held across its own clear
        wr_chk(setup_regs_pkg::OFS_EVENT_FLAGS, 32'h08, 4'h1, 2'h0);
        event_in <= 8'h00;
        rd_chk("set beats clear", setup_regs_pkg::OFS_EVENT_FLAGS, 32'h08, 2'h0);
        wr_chk(setup_regs_pkg::OFS_EVENT_FLAGS, 32'hFF, 4'h1, 2'h0);
        wr_chk(setup_regs_pkg::OFS_FRAME_CTRL, 32'h1, 4'h1, 2'h0);
        repeat (FC + 5) @(posedge sys_clk);
        rd_chk("frame flag", setup_regs_pkg::OFS_EVENT_FLAGS, 32'h10, 2'h0);
        wr_chk(setup_regs_pkg::OFS_FRAME_CTRL, 32'h0, 4'h1, 2'h0);
        wr_chk(8'h14, 32'hFFFF, 4'hF, setup_regs_pkg::RESP_SLVERR);
        final_report();
    end
endmodule
